/* logic/ebp_pkg.sv */
// Package of constants and types for the eight-bit port block
// Functional notes
// - Direction bit 1 drives latch, 0 inputs
// - Direction write-only; read returns neighbour port pins
// - Direction clears on reset, hardware standby only
// - Output latch always readable and writable
// - Output latch clears on reset, hardware standby
// - Pin-level register reads present pin levels
// - Modes 1,2: host enable hands pins over
// - Mode 3: all pins general I/O
// - Mode 3 pull-up when latch 1, direction 0
// - Pull-ups off in reset; held in software standby
package ebp_pkg;

    // Port width
    localparam int unsigned PORT_W = 8;
    // APB data width and byte address width
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 18;
    // Synchroniser depth for pins and straps
    localparam int unsigned SYNC_STAGES = 2;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_LATCH = 16'hffbc;
    localparam logic [15:0] IDX_PINS = 16'hffbd;
    localparam logic [15:0] IDX_DIR = 16'hffbe;
    localparam logic [15:0] IDX_SYSCTL = 16'hffbf;

    // Byte addresses on the APB
    localparam logic [ADDR_W-1:0] ADDR_LATCH = {IDX_LATCH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PINS = {IDX_PINS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIR = {IDX_DIR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SYSCTL = {IDX_SYSCTL, 2'h0};

    // Values after reset
    localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
    localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
    localparam logic [PORT_W-1:0] PULLUP_RST = 8'h00;
    localparam logic HOST_EN_RST = 1'h0;
    localparam logic [PORT_W-1:0] OE_N_RST = 8'hff;

    // Field positions in system_control_reg
    localparam int unsigned SYSCTL_HIE_BIT = 0;
    localparam int unsigned SYSCTL_MODE_LSB = 4;
    localparam int unsigned SYSCTL_HWSTBY_BIT = 6;
    localparam int unsigned SYSCTL_SWSTBY_BIT = 7;

    // Operating modes from the mode straps
    typedef enum logic [1:0] {
        EBP_MODE_RSVD = 2'b00,
        EBP_MODE_EXP_NOROM = 2'b01,
        EBP_MODE_EXP_ROM = 2'b10,
        EBP_MODE_SINGLE = 2'b11
    } ebp_mode_t;

    // Per-pin drive request: data and drive enable
    typedef struct packed {
        logic [PORT_W-1:0] data;
        logic [PORT_W-1:0] drive;
    } ebp_pin_drive_t;

endpackage

/* logic/ebp_sync.sv */
// Two-flop synchroniser for pin inputs and straps
`timescale 1ns/1ps
module ebp_sync
    import ebp_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Asynchronous levels in, synchronous levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage; read only by the second stage
    logic [WIDTH-1:0] meta;

    // Both stages freeze with the clock enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // ebp_sync

/* logic/ebp_pin_mux.sv */
// Per-pin selection between port logic and host interface
`timescale 1ns/1ps
module ebp_pin_mux
    import ebp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Source selection
    input wire logic host_owned,
    input wire logic [PORT_W-1:0] port_direction,
    input wire logic [PORT_W-1:0] port_output_latch,
    input wire ebp_pin_drive_t host_drive,
    // Pin drivers, enable active low
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe_n
);

    genvar gi;

    // One registered driver per pin, so pins never glitch on decode
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out[gi] <= LATCH_RST[gi];
                    pin_oe_n[gi] <= OE_N_RST[gi];
                end else if (ce) begin
                    if (host_owned) begin
                        // Host bus owns the pin
                        pin_out[gi] <= host_drive.data[gi];
                        pin_oe_n[gi] <= ~host_drive.drive[gi];
                    end else begin
                        // General I/O by direction bit
                        pin_out[gi] <= port_output_latch[gi];
                        pin_oe_n[gi] <= ~port_direction[gi];
                    end
                end
            end
        end
    endgenerate

endmodule // ebp_pin_mux

/* logic/ebp_port.sv */
// Eight-bit port with pull-ups, APB registers and host takeover
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module ebp_port
    import ebp_pkg::*;
(
    // Clock, reset, clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins and straps from outside
    input wire logic [PORT_W-1:0] pin_in,
    input wire logic [1:0] mode_pins,
    input wire logic hw_standby_pin,
    // Chip-side inputs on this clock
    input wire logic sw_standby,
    input wire logic [PORT_W-1:0] neighbour_port_pin_levels,
    input wire ebp_pin_drive_t host_drive,
    // Host interface read path
    output logic [PORT_W-1:0] host_data_in,
    // Pin drivers and pull-up controls
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe_n,
    output logic [PORT_W-1:0] pullup_en
);

    // Synchronised pins, straps and hardware standby
    logic [PORT_W-1:0] pins_s;
    logic [1:0] mode_raw;
    logic hw_clear;
    ebp_mode_t mode_s;

    // Software-visible registers
    logic [PORT_W-1:0] port_output_latch;
    logic [PORT_W-1:0] port_direction;
    logic host_port_enable;

    // Decode results
    logic hit_latch;
    logic hit_pins;
    logic hit_dir;
    logic hit_sysctl;
    logic mapped;

    // Bus phase strobes
    logic setup_ph;
    logic access_ph;
    logic wr;

    // Derived control
    logic host_owned;
    logic single_chip;
    logic [PORT_W-1:0] pull_target;
    logic [PORT_W-1:0] next_pullup;
    logic [DATA_W-1:0] next_prdata;

    // Pins, mode straps and standby pin cross in through two flops
    ebp_sync #(
        .WIDTH(PORT_W + 3)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({hw_standby_pin, mode_pins, pin_in}),
        .sync_out({hw_clear, mode_raw, pins_s})
    );

    // Cast the strap pair to the mode type
    assign mode_s = ebp_mode_t'(mode_raw);

    // Host data bus sees the synchronised pin levels
    assign host_data_in = pins_s;

    // Address decode
    always_comb begin
        hit_latch = 1'b0;
        hit_pins = 1'b0;
        hit_dir = 1'b0;
        hit_sysctl = 1'b0;
        if (paddr == ADDR_LATCH) begin
            hit_latch = 1'b1;
        end else if (paddr == ADDR_PINS) begin
            hit_pins = 1'b1;
        end else if (paddr == ADDR_DIR) begin
            hit_dir = 1'b1;
        end else if (paddr == ADDR_SYSCTL) begin
            hit_sysctl = 1'b1;
        end
    end

    // Any of the four words counts as mapped
    assign mapped = hit_latch | hit_pins | hit_dir | hit_sysctl;

    // Zero-wait slave; a frozen block stalls the bus
    assign pready = ce;

    // Setup and access phases
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;

    // Error only in the access phase, for an unmapped word
    assign pslverr = access_ph & ~mapped;

    // Write takes effect at the completing edge; low byte lane only
    assign wr = access_ph & pwrite & ce & pstrb[0];

    // Host takeover exists in every mode except single-chip mode 3
    assign single_chip = (mode_s == EBP_MODE_SINGLE);
    assign host_owned = host_port_enable & ~single_chip;

    // Output latch: readable and writable in any direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_output_latch <= LATCH_RST;
        end else if (ce) begin
            if (hw_clear) begin
                // Hardware standby clears the latch
                port_output_latch <= LATCH_RST;
            end else if (wr && hit_latch) begin
                // No direction term here on purpose
                port_output_latch <= pwdata[PORT_W-1:0];
            end
        end
    end

    // Direction register: write-only, kept through software standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction <= DIR_RST;
        end else if (ce) begin
            if (hw_clear) begin
                // Only hardware standby clears it
                port_direction <= DIR_RST;
            end else if (wr && hit_dir) begin
                // Write path only; reads go elsewhere
                port_direction <= pwdata[PORT_W-1:0];
            end
        end
    end

    // System control: host port enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_port_enable <= HOST_EN_RST;
        end else if (ce) begin
            if (hw_clear) begin
                host_port_enable <= HOST_EN_RST;
            end else if (wr && hit_sysctl) begin
                host_port_enable <= pwdata[SYSCTL_HIE_BIT];
            end
        end
    end

    // Pull-up wanted: latch high on an input pin, mode 3 only
    assign pull_target = port_output_latch & ~port_direction;

    // Next pull-up value; software standby keeps the old one
    always_comb begin
        next_pullup = pullup_en;
        if (hw_clear) begin
            // Forced off in hardware standby
            next_pullup = PULLUP_RST;
        end else if (!sw_standby) begin
            if (single_chip) begin
                // Per-bit on when latch 1, direction 0
                next_pullup = pull_target;
            end else begin
                next_pullup = PULLUP_RST;
            end
        end
    end

    // Pull-up register; asynchronous reset turns all off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_en <= PULLUP_RST;
        end else if (ce) begin
            pullup_en <= next_pullup;
        end
    end

    // Read data, chosen during the setup phase
    always_comb begin
        next_prdata = '0;
        if (hit_latch) begin
            // Stored latch value
            next_prdata[PORT_W-1:0] = port_output_latch;
        end else if (hit_pins) begin
            // Present pin levels, not the latch
            next_prdata[PORT_W-1:0] = pins_s;
        end else if (hit_dir) begin
            // Shared address shows the neighbour port
            next_prdata[PORT_W-1:0] = neighbour_port_pin_levels;
        end else if (hit_sysctl) begin
            next_prdata[SYSCTL_HIE_BIT] = host_port_enable;
            next_prdata[SYSCTL_MODE_LSB +: 2] = mode_raw;
            next_prdata[SYSCTL_HWSTBY_BIT] = hw_clear;
            next_prdata[SYSCTL_SWSTBY_BIT] = sw_standby;
        end
    end

    // Read data register; holds through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && setup_ph) begin
            prdata <= next_prdata;
        end
    end

    // Pin drivers, registered per pin
    ebp_pin_mux u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .host_owned(host_owned),
        .port_direction(port_direction),
        .port_output_latch(port_output_latch),
        .host_drive(host_drive),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );

    // Checks on the documented behaviour

    // Port drives latch where direction is 1
    property p_dir_drive;
        @(posedge pclk) disable iff (!presetn)
        ce && !host_owned |=>
            (pin_oe_n == ~$past(port_direction)) &&
            (pin_out == $past(port_output_latch));
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("port pins do not follow direction and latch");

    // Direction address reads the neighbour port
    property p_dir_read;
        @(posedge pclk) disable iff (!presetn)
        ce && setup_ph && hit_dir |=>
            prdata == {24'h0, $past(neighbour_port_pin_levels)};
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction address did not return neighbour pins");

    // Hardware standby clears direction within one edge
    property p_dir_clear;
        @(posedge pclk) disable iff (!presetn)
        ce && hw_clear |=> port_direction == 8'h00;
    endproperty
    a_dir_clear: assert property (p_dir_clear)
        else $error("direction not cleared in hardware standby");

    // Software standby without writes keeps direction
    property p_dir_keep;
        @(posedge pclk) disable iff (!presetn)
        ce && sw_standby && !hw_clear && !wr |=> $stable(port_direction);
    endproperty
    a_dir_keep: assert property (p_dir_keep)
        else $error("direction changed in software standby");

    // A latch write reaches the output latch on the next edge
    property p_latch_rw;
        @(posedge pclk) disable iff (!presetn)
        ce && wr && hit_latch && !hw_clear |=>
            port_output_latch == $past(pwdata[7:0]);
    endproperty
    a_latch_rw: assert property (p_latch_rw)
        else $error("latch write lost");

    // Latch clears in hardware standby
    property p_latch_clear;
        @(posedge pclk) disable iff (!presetn)
        ce && hw_clear |=> port_output_latch == 8'h00;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("latch not cleared in hardware standby");

    // Pin-level reads return pins
    property p_pins_read;
        @(posedge pclk) disable iff (!presetn)
        ce && setup_ph && hit_pins |=>
            prdata == {24'h0, $past(pins_s)};
    endproperty
    a_pins_read: assert property (p_pins_read)
        else $error("pin read did not return pin levels");

    // Host interface drives the pins when it owns them
    property p_host_mux;
        @(posedge pclk) disable iff (!presetn)
        ce && host_owned |=>
            (pin_oe_n == ~$past(host_drive.drive)) &&
            (pin_out == $past(host_drive.data));
    endproperty
    a_host_mux: assert property (p_host_mux)
        else $error("host-owned pins driven by port registers");

    // Mode 3 pull-ups follow latch and direction
    property p_pull_mode3;
        @(posedge pclk) disable iff (!presetn)
        ce && single_chip && !hw_clear && !sw_standby |=>
            pullup_en == $past(pull_target);
    endproperty
    a_pull_mode3: assert property (p_pull_mode3)
        else $error("pull-ups do not match latch and direction");

    // Pull-ups off in hardware standby, held in software standby
    property p_pull_standby;
        @(posedge pclk) disable iff (!presetn)
        ce && (hw_clear || sw_standby) |=>
            (pullup_en == ($past(hw_clear) ? 8'h00 : $past(pullup_en)));
    endproperty
    a_pull_standby: assert property (p_pull_standby)
        else $error("pull-up state wrong in standby");

    // Mode 3 keeps the pins general I/O even with host enable set
    property p_single_gpio;
        @(posedge pclk) disable iff (!presetn)
        ce && single_chip |=>
            (pin_oe_n == ~$past(port_direction)) &&
            (pin_out == $past(port_output_latch));
    endproperty
    a_single_gpio: assert property (p_single_gpio)
        else $error("mode 3 pins not under direction control");

    // Pull-ups stay off outside mode 3 unless software standby holds them
    property p_pull_expanded;
        @(posedge pclk) disable iff (!presetn)
        ce && !single_chip && !sw_standby |=> pullup_en == 8'h00;
    endproperty
    a_pull_expanded: assert property (p_pull_expanded)
        else $error("pull-up on outside mode 3");

    // Software standby keeps the latch unless software writes it
    property p_latch_keep;
        @(posedge pclk) disable iff (!presetn)
        ce && sw_standby && !hw_clear && !(wr && hit_latch) |=> $stable(port_output_latch);
    endproperty
    a_latch_keep: assert property (p_latch_keep)
        else $error("latch changed in software standby");

endmodule // ebp_port

/* test/ebp_pin_model.sv */
// Pin-side model: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
module ebp_pin_model
    import ebp_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Drive from the block
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe_n,
    input wire logic [PORT_W-1:0] pullup_en,
    // External drivers commanded by the bench
    input wire logic [PORT_W-1:0] ext_val,
    input wire logic [PORT_W-1:0] ext_en,
    // Resolved pin levels
    output logic [PORT_W-1:0] pin_in
);
    // Undriven pins wander every cycle so a stale level never passes
    logic [PORT_W-1:0] float_lvl = 8'h5a;
    always @(posedge pclk) begin
        float_lvl <= ~float_lvl;
    end
    // Block drive wins, then external drive, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_lvl[i];
            end
        end
    end
endmodule // ebp_pin_model

/* test/ebp_port_tb.sv */
// Self-checking bench for the eight-bit port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ebp_port_tb;
    import ebp_pkg::*;
    // Design stimulus
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'h1;
    logic pready, pslverr, hw_standby_pin = 0, sw_standby = 0;
    logic [1:0] mode_pins = 2'h3;
    logic [PORT_W-1:0] pin_in, nbr = '0, host_data_in, pin_out, pin_oe_n, pullup_en;
    logic [PORT_W-1:0] ext_val = '0, ext_en = '0, lat, dir, lvl;
    ebp_pin_drive_t host_drive = '0, hd;
    // Scoreboard notes: name and expected value
    typedef struct {string nm; logic [32:0] e;} ebp_note_t;
    ebp_note_t notes[$];
    logic [2:0] probe_sel = 3'h0;
    int n_mismatch = 0, check_count = 0;

    ebp_port ebp_port_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .mode_pins(mode_pins), .hw_standby_pin(hw_standby_pin), .sw_standby(sw_standby),
        .neighbour_port_pin_levels(nbr), .host_drive(host_drive),
        .host_data_in(host_data_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en));
    ebp_pin_model ebp_pin_model_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    // Clock at 200 MHz
    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // Monitor: pops the oldest note when a read completes or a probe is due
    always @(posedge pclk) begin
        ebp_note_t n;
        logic [32:0] got;
        got = {pslverr, prdata};
        if (probe_sel == 3'h1) got = {25'h0, pin_oe_n};
        if (probe_sel == 3'h2) got = {25'h0, pullup_en};
        if (probe_sel == 3'h3) got = {25'h0, pin_out};
        if (probe_sel == 3'h4) got = {25'h0, host_data_in};
        if ((psel && penable && pready && !pwrite) || probe_sel != 3'h0) begin
            if (notes.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] note queue empty");
            end else begin
                n = notes.pop_front();
                `CHK(n.nm, n.e, got)
            end
        end
    end

    // One APB transfer; a read files its expected {pslverr, prdata} first
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [32:0] e, input string nm);
        if (!w) notes.push_back('{nm, e});
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Wait for pready as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask
    // Look at one registered output on the next edge
    task automatic probe(input logic [2:0] s, input logic [7:0] e, input string nm);
        notes.push_back('{nm, {25'h0, e}});
        @(posedge pclk);
        probe_sel <= s;
        @(posedge pclk);
        probe_sel <= 3'h0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        idle(20000);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h222c));
        idle(12);
        presetn <= 1;
        idle(3);
        nbr <= 8'($urandom());
        apb(0, ADDR_LATCH, 0, 33'h0, "latch after reset");
        apb(0, ADDR_DIR, 0, {25'h0, nbr}, "dir address reads neighbour");
        probe(3'h1, 8'hff, "oe_n after reset");
        probe(3'h2, 8'h00, "pullup after reset");
        apb(0, ADDR_SYSCTL + 18'h10, 0, 33'h1_0000_0000, "unmapped read");
        $display("test reset done");
        // Mode 3 general I/O with random latch and direction
        for (int k = 0; k < 4; k++) begin
            lat = 8'($urandom());
            dir = (k == 0) ? 8'h00 : 8'($urandom());
            apb(1, ADDR_LATCH, {24'h0, lat}, 0, "");
            apb(1, ADDR_DIR, {24'h0, dir}, 0, "");
            apb(1, ADDR_PINS, 32'hff, 0, "");
            ext_val <= 8'($urandom());
            ext_en <= ~dir | 8'h0f;
            idle(6);
            apb(0, ADDR_LATCH, 0, {25'h0, lat}, "latch readback");
            probe(3'h1, ~dir, "oe_n follows dir");
            probe(3'h3, lat, "pin_out follows latch");
            probe(3'h2, lat & ~dir, "pullup mode3");
            apb(0, ADDR_PINS, 0, {25'h0, (lat & dir) | (ext_val & ~dir)}, "pins");
            ext_en <= ~dir;
        end
        $display("test general io done");
        // Frozen block: a strap change is not seen until the enable returns
        ce <= 0;
        mode_pins <= 2'h1;
        idle(4);
        probe(3'h2, lat & ~dir, "pullup frozen");
        ce <= 1;
        idle(4);
        probe(3'h2, 8'h00, "pullup off in mode 1");
        mode_pins <= 2'h3;
        idle(4);
        $display("test clock enable done");
        // Software standby holds pull-ups and direction; a latch write still lands
        sw_standby <= 1;
        apb(1, ADDR_LATCH, {24'h0, ~lat}, 0, "");
        idle(3);
        probe(3'h2, lat & ~dir, "pullup held");
        probe(3'h1, ~dir, "dir held");
        apb(0, ADDR_LATCH, 0, {25'h0, ~lat}, "latch in sw standby");
        sw_standby <= 0;
        // A write with the low byte lane off leaves the latch alone
        pstrb <= 4'h0;
        apb(1, ADDR_LATCH, {24'h0, lat}, 0, "");
        pstrb <= 4'h1;
        apb(0, ADDR_LATCH, 0, {25'h0, ~lat}, "latch lane off");
        $display("test sw standby done");
        // Expanded mode: clear port registers, then hand pins to the host
        mode_pins <= 2'h1;
        apb(1, ADDR_LATCH, 0, 0, "");
        apb(1, ADDR_DIR, 0, 0, "");
        hd = '{data: 8'($urandom()), drive: 8'($urandom())};
        host_drive <= hd;
        ext_val <= 8'($urandom());
        ext_en <= ~hd.drive;
        apb(1, ADDR_SYSCTL, 32'h1, 0, "");
        idle(4);
        lvl = (hd.data & hd.drive) | (ext_val & ~hd.drive);
        probe(3'h3, hd.data, "host data");
        probe(3'h1, ~hd.drive, "host drive");
        probe(3'h4, lvl, "host data in");
        apb(0, ADDR_PINS, 0, {25'h0, lvl}, "host pins");
        apb(1, ADDR_SYSCTL, 32'h0, 0, "");
        idle(3);
        probe(3'h1, 8'hff, "gpio again");
        $display("test host takeover done");
        // Mode 3 ignores host enable; hardware standby then clears everything
        mode_pins <= 2'h3;
        apb(1, ADDR_SYSCTL, 32'h1, 0, "");
        apb(1, ADDR_LATCH, 32'hff, 0, "");
        apb(1, ADDR_DIR, 32'h0f, 0, "");
        idle(4);
        probe(3'h1, 8'hf0, "mode 3 keeps gpio");
        hw_standby_pin <= 1;
        idle(4);
        probe(3'h2, 8'h00, "pullup in hw standby");
        idle(2);
        hw_standby_pin <= 0;
        idle(4);
        apb(0, ADDR_LATCH, 0, 33'h0, "latch hw standby");
        probe(3'h1, 8'hff, "dir hw standby");
        probe(3'h2, 8'h00, "pullup hw standby");
        apb(0, ADDR_SYSCTL, 0, 33'h30, "host enable hw standby");
        $display("test hw standby done");
        idle(4);
        final_report();
    end
endmodule // ebp_port_tb
